// [logic/mpsd_pkg.sv]
// package for the pin-five sequence delay and power-good selector
package mpsd_pkg;
   // ****************************************
   // register map (no printed offsets: indices of this block's own port)
   // ****************************************
   localparam logic [0:0] ADDR_ON_DELAY = 1'h0;
   localparam logic [0:0] ADDR_OFF_DELAY = 1'h1;
   localparam logic [7:0] RST_ON_DELAY = 8'h00;
   localparam logic [7:0] RST_OFF_DELAY = 8'h00;
   localparam int DLY_MSB = 6;
   localparam int SEL_MSB = 3;
   // ****************************************
   // selector codes
   // ****************************************
   localparam logic [3:0] SEL_SW_FIRST = 4'h0;
   localparam logic [3:0] SEL_LIN_FIRST = 4'h6;
   localparam logic [3:0] SEL_TERM_REF = 4'h9;
   localparam logic [3:0] SEL_ALL = 4'hA;
   localparam int NUM_REG = 10;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_MHZ = 100;
   localparam int MS_TIME_US = 1000;
   localparam int MS_CYCLES = CLK_MHZ * MS_TIME_US;
   typedef struct packed {
      logic wr;
      logic addr;
      logic [7:0] wdata;
   } mpsd_req_t;
   typedef struct packed {
      logic load;
      logic [7:0] on_val;
      logic [7:0] off_val;
   } mpsd_nvm_t;
endpackage : mpsd_pkg

// [logic/mpsd_top.sv]
// pin-five sequence delay and power-good selector
`timescale 1ns/100ps
module mpsd_top #(
   parameter int MS_CYC = mpsd_pkg::MS_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire mpsd_pkg::mpsd_req_t i_req,
   input wire mpsd_pkg::mpsd_nvm_t i_nvm,
   input wire logic i_seq_on_start,
   input wire logic i_seq_off_start,
   input wire logic i_regulator_ok_flag_mode,
   input wire logic [mpsd_pkg::NUM_REG-1:0] i_regulator_ok_flag,
   output logic [7:0] o_rdata,
   output logic o_multipurpose_pin_five
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_ON = 3'h2,
      ST_OFF = 3'h4
   } mpsd_state_t;
   // ****************************************
   // input synchronisers (regulator flags come from analogue domain)
   // ****************************************
   logic [mpsd_pkg::NUM_REG-1:0] ok_s1_q, ok_s2_q;
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ok_s1_q <= '0;
         ok_s2_q <= '0;
      end else begin
         ok_s1_q <= i_regulator_ok_flag;
         ok_s2_q <= ok_s1_q;
      end
   end
   // ****************************************
   // registers
   // ****************************************
   logic [7:0] on_q, on_d, off_q, off_d, rdata_d;
   always_comb begin
      on_d = on_q;
      off_d = off_q;
      if (i_nvm.load) begin
         on_d = i_nvm.on_val;
         off_d = i_nvm.off_val;
      end else if (i_req.wr) begin
         if (i_req.addr == mpsd_pkg::ADDR_ON_DELAY) on_d = i_req.wdata;
         else off_d = i_req.wdata;
      end
      rdata_d = (i_req.addr == mpsd_pkg::ADDR_ON_DELAY) ? on_q : off_q;
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         on_q <= mpsd_pkg::RST_ON_DELAY;
         off_q <= mpsd_pkg::RST_OFF_DELAY;
         o_rdata <= 8'h00;
      end else begin
         on_q <= on_d;
         off_q <= off_d;
         o_rdata <= rdata_d;
      end
   end
   // ****************************************
   // millisecond tick and sequence timer
   // ****************************************
   logic [31:0] div_q, div_d;
   logic [6:0] ms_q, ms_d;
   logic pin_q, pin_d, tick;
   mpsd_state_t st_q, st_d;
   // reserved codes give a deasserted flag rather than an arbitrary regulator
   function automatic logic sel_ok(input logic [3:0] sel,
                                   input logic [mpsd_pkg::NUM_REG-1:0] ok);
      if (sel == mpsd_pkg::SEL_ALL) return &ok;
      if (sel <= mpsd_pkg::SEL_TERM_REF) return ok[sel];
      return 1'b0;
   endfunction : sel_ok
   assign tick = (div_q == 32'(MS_CYC - 1));
   always_comb begin
      div_d = tick ? 32'h0 : div_q + 32'h1;
      st_d = st_q;
      ms_d = ms_q;
      pin_d = pin_q;
      // a new sequence restarts the divider so the first millisecond is whole
      if (i_seq_on_start) begin
         st_d = ST_ON;
         ms_d = 7'h00;
         div_d = 32'h0;
      end else if (i_seq_off_start) begin
         st_d = ST_OFF;
         ms_d = 7'h00;
         div_d = 32'h0;
      end else begin
         case (st_q)
            ST_IDLE: ;
            ST_ON: begin
               if (ms_q == on_q[mpsd_pkg::DLY_MSB:0]) begin
                  pin_d = 1'b1;
                  st_d = ST_IDLE;
               end else if (tick) ms_d = ms_q + 7'h01;
            end
            ST_OFF: begin
               if (ms_q == off_q[mpsd_pkg::DLY_MSB:0]) begin
                  pin_d = 1'b0;
                  st_d = ST_IDLE;
               end else if (tick) ms_d = ms_q + 7'h01;
            end
            default: st_d = ST_IDLE;
         endcase
      end
      if (i_regulator_ok_flag_mode) pin_d = sel_ok(on_q[mpsd_pkg::SEL_MSB:0], ok_s2_q);
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         div_q <= 32'h0;
         ms_q <= 7'h00;
         st_q <= ST_IDLE;
         pin_q <= 1'b0;
      end else begin
         div_q <= div_d;
         ms_q <= ms_d;
         st_q <= st_d;
         pin_q <= pin_d;
      end
   end
   assign o_multipurpose_pin_five = pin_q;
   // ****************************************
   // assertions
   // ****************************************
   property p_on_zero;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (st_q == ST_ON && on_q[6:0] == 7'h00 && !i_regulator_ok_flag_mode && !i_seq_on_start
       && !i_seq_off_start) |=> o_multipurpose_pin_five;
   endproperty
   a_on_zero: assert property (p_on_zero) else $error("zero on delay not immediate");
   property p_on_wait;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (st_q == ST_ON && ms_q < on_q[6:0] && !i_seq_off_start && !i_regulator_ok_flag_mode)
      |=> (st_q == ST_ON || i_regulator_ok_flag_mode || $past(i_seq_on_start));
   endproperty
   a_on_wait: assert property (p_on_wait) else $error("on sequence ended early");
   property p_top_bit;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (st_q == ST_ON) |-> (ms_q <= on_q[6:0]);
   endproperty
   a_top_bit: assert property (p_top_bit) else $error("count passed delay");
   property p_sel;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_regulator_ok_flag_mode && on_q[3:0] <= 4'h9)
      |=> o_multipurpose_pin_five == $past(ok_s2_q[on_q[3:0]]);
   endproperty
   a_sel: assert property (p_sel) else $error("wrong regulator selected");
   property p_all;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_regulator_ok_flag_mode && on_q[3:0] == 4'hA) |=> o_multipurpose_pin_five == &$past(ok_s2_q);
   endproperty
   a_all: assert property (p_all) else $error("and of flags wrong");
   property p_off_zero;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (st_q == ST_OFF && off_q[6:0] == 7'h00 && !i_regulator_ok_flag_mode && !i_seq_on_start
       && !i_seq_off_start) |=> !o_multipurpose_pin_five;
   endproperty
   a_off_zero: assert property (p_off_zero) else $error("zero off delay not immediate");
   property p_wr;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_req.wr && !i_nvm.load && i_req.addr == 1'b1) |=> off_q == $past(i_req.wdata);
   endproperty
   a_wr: assert property (p_wr) else $error("off delay write lost");
   property p_rsv;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_regulator_ok_flag_mode && on_q[3:0] > 4'hA) |=> !o_multipurpose_pin_five;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved code drove pin");
   property p_on_done;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (st_q == ST_ON && ms_q == on_q[6:0] && !i_regulator_ok_flag_mode && !i_seq_on_start
       && !i_seq_off_start) |=> (o_multipurpose_pin_five && st_q == ST_IDLE);
   endproperty
   a_on_done: assert property (p_on_done) else $error("on delay did not end");
   property p_off_wait;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (st_q == ST_OFF && ms_q < off_q[6:0] && !i_seq_on_start && !i_regulator_ok_flag_mode)
      |=> (st_q == ST_OFF || i_regulator_ok_flag_mode || $past(i_seq_off_start));
   endproperty
   a_off_wait: assert property (p_off_wait) else $error("off sequence ended early");
   property p_off_done;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (st_q == ST_OFF && ms_q == off_q[6:0] && !i_regulator_ok_flag_mode && !i_seq_on_start
       && !i_seq_off_start) |=> (!o_multipurpose_pin_five && st_q == ST_IDLE);
   endproperty
   a_off_done: assert property (p_off_done) else $error("off delay did not end");
   property p_load;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      i_nvm.load |=> (on_q == $past(i_nvm.on_val) && off_q == $past(i_nvm.off_val));
   endproperty
   a_load: assert property (p_load) else $error("nonvolatile load lost");
   property p_on_wr;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_req.wr && !i_nvm.load && i_req.addr == 1'b0) |=> on_q == $past(i_req.wdata);
   endproperty
   a_on_wr: assert property (p_on_wr) else $error("on delay write lost");
   // read data lags the index by one cycle, so a master must let one edge pass
   property p_rd;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (i_req.addr == 1'b0) |=> o_rdata == $past(on_q);
   endproperty
   a_rd: assert property (p_rd) else $error("on delay read wrong");
   // ****************************************
   // covers
   // ****************************************
   c_on: cover property (@(posedge i_ref_clk) st_q == ST_ON ##1 st_q == ST_IDLE);
   c_off: cover property (@(posedge i_ref_clk) st_q == ST_OFF ##1 st_q == ST_IDLE);
   c_all: cover property (@(posedge i_ref_clk) i_regulator_ok_flag_mode && on_q[3:0] == 4'hA);
   c_rsv: cover property (@(posedge i_ref_clk) i_regulator_ok_flag_mode && on_q[3:0] > 4'hA);
   c_load: cover property (@(posedge i_ref_clk) i_nvm.load);
endmodule : mpsd_top

// [tb/mpsd_pin_watch.sv]
// partner model: system logic counting level changes on the sequenced pin
`timescale 1ns/100ps
module mpsd_pin_watch (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic i_pin,
   output int o_edges
);
   // ****************************************
   // edge counter: a glitch on the pin shows up as extra edges
   // ****************************************
   logic last_q;
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         last_q <= 1'b0;
         o_edges <= 0;
      end else begin
         last_q <= i_pin;
         if (i_pin !== last_q) o_edges <= o_edges + 1;
      end
   end
endmodule : mpsd_pin_watch

// [tb/mpsd_top_test.sv]
// self-checking bench for the pin-five delay and selector block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module mpsd_top_test;
   // ****************************************
   // stimulus and checks
   // ****************************************
   logic clk = 1'b0, rst_b, on_s, off_s, pg_mode, pin;
   mpsd_pkg::mpsd_req_t req;
   mpsd_pkg::mpsd_nvm_t nvm;
   logic [mpsd_pkg::NUM_REG-1:0] ok;
   logic [7:0] rdata, v1, v2;
   logic [6:0] dl [5];
   int edges, miscompares = 0, checked = 0, cycles = 0, n;
   mpsd_top #(.MS_CYC(4)) i_mpsd_top (.i_ref_clk(clk), .i_rst_b(rst_b), .i_req(req),
      .i_nvm(nvm), .i_seq_on_start(on_s), .i_seq_off_start(off_s),
      .i_regulator_ok_flag_mode(pg_mode), .i_regulator_ok_flag(ok), .o_rdata(rdata),
      .o_multipurpose_pin_five(pin));
   mpsd_pin_watch i_mpsd_pin_watch (.i_ref_clk(clk), .i_rst_b(rst_b), .i_pin(pin),
      .o_edges(edges));
   initial forever #5 clk = ~clk;
   // generous ceiling: ten sequences of at most 127 ms-ticks plus selector sweep
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         miscompares++;
         report_and_stop();
      end
   end
   task tick; @(posedge clk); #1; endtask : tick
   task wr(input logic a, input logic [7:0] d);
      req.wr = 1'b1; req.addr = a; req.wdata = d; tick; req.wr = 1'b0; tick;
   endtask : wr
   task rd(input logic a, input logic [7:0] e);
      req.addr = a; tick; `CHK("rdata", e, rdata)
   endtask : rd
   function automatic logic exp_pg(input logic [3:0] s, input logic [9:0] f);
      if (s < 4'hA) return f[s];
      return (s == 4'hA) ? &f : 1'b0; // reserved codes read as not good
   endfunction : exp_pg
   task seq(input logic on, input logic [6:0] ms);
      int lo;
      lo = ms * 4;
      wr(!on, {1'($urandom), ms}); // top bit random: it must not alter the delay
      if (on) on_s = 1'b1; else off_s = 1'b1;
      tick; on_s = 1'b0; off_s = 1'b0; n = 1;
      while (pin !== on && n < 2000) begin tick; n++; end
      `CHK("seq_time", 1'b1, (n >= lo + 1 && n <= lo + 3))
   endtask : seq
   task report_and_stop;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : report_and_stop
   initial begin
      rst_b = 1'b0; on_s = 1'b0; off_s = 1'b0; pg_mode = 1'b0;
      req = '0; nvm = '0; ok = '0;
      void'($urandom(6));
      repeat (8) @(posedge clk);
      #1 rst_b = 1'b1;
      rd(1'h0, 8'h00);
      rd(1'h1, 8'h00);
      dl = '{7'h00, 7'h7F, 7'($urandom), 7'($urandom % 8), 7'h01};
      foreach (dl[i]) begin
         seq(1'b1, dl[i]);
         seq(1'b0, dl[4 - i]);
      end
      tick; // the watcher counts the last edge one clock after the pin moves
      `CHK("edges", 10, edges)
      v1 = 8'($urandom); v2 = 8'($urandom);
      nvm = '{1'b1, v1, v2}; req = '{1'b1, 1'h0, ~v1}; // write lost under load
      tick; nvm.load = 1'b0; req.wr = 1'b0;
      rd(1'h0, v1);
      rd(1'h1, v2);
      pg_mode = 1'b1;
      for (int s = 0; s < 16; s++) begin
         v1 = {4'($urandom), 4'(s)};
         wr(1'h0, v1);
         rd(1'h0, v1);
         for (int k = 0; k < 3; k++) begin
            ok = (k == 0) ? '1 : 10'($urandom);
            repeat (5) tick;
            `CHK("pg_pin", exp_pg(4'(s), ok), pin)
         end
      end
      report_and_stop();
   end
endmodule : mpsd_top_test
